// >>> common/ifmu_regs.svh
// Function
// - A source's pending flag sets on its event even while its mask bit is 0.
// - An uncleared, unmasked flag keeps requesting, so it re-fires after enable or return.
// - After reset cpuIntReq and cpuNmiReq (NMI) are blocked until both stack pointers are written; the group irq is not.
// - Rewriting one stack pointer blocks cpuIntReq and cpuNmiReq again until the other is rewritten.
// - Every pending flag is 0 after reset.
// - Unused flag and mask bits read 0 and ignore writes.
// - Timer flags in timer pending bits 1,0; serial and key flags in bit 0.
// - Clock-timer pending: bit 3 1 Hz, 2 2 Hz, 1 8 Hz, 0 32 Hz.
// - Stopwatch pending: bit 1 for 1 Hz, bit 0 for 10 Hz.
// - Masks: serial in bit 0, stopwatch bits 1,0, programmable timers bits 1,0.
// - Key selection and comparison registers per group; key masks in bit 0.
// - Each selection bit decides whether its key input may raise the group interrupt.
`ifndef IFMU_REGS_SVH
`define IFMU_REGS_SVH
`define IFMU_IDX_KSEL0 16'hFF20
`define IFMU_IDX_KCMP0 16'hFF22
`define IFMU_IDX_KSEL1 16'hFF24
`define IFMU_IDX_KCMP1 16'hFF26
`define IFMU_IDX_MPT 16'hFFE2
`define IFMU_IDX_MSER 16'hFFE3
`define IFMU_IDX_MK0 16'hFFE4
`define IFMU_IDX_MK1 16'hFFE5
`define IFMU_IDX_MCLK 16'hFFE6
`define IFMU_IDX_MSW 16'hFFE7
`define IFMU_IDX_PPT 16'hFFF2
`define IFMU_IDX_PSER 16'hFFF3
`define IFMU_IDX_PK0 16'hFFF4
`define IFMU_IDX_PK1 16'hFFF5
`define IFMU_IDX_PCLK 16'hFFF6
`define IFMU_IDX_PSW 16'hFFF7
`define IFMU_IDX_ISTAT 16'hFF30
`define IFMU_IDX_IMASK 16'hFF31
`define IFMU_IDX_SPSTAT 16'hFF32
`define IFMU_BITS_PT 4'h3
`define IFMU_BITS_ONE 4'h1
`define IFMU_BITS_CLK 4'hF
`define IFMU_BITS_SW 4'h3
`define IFMU_RST_FLAG 4'h0
`define IFMU_RST_MASK 4'h0
`define IFMU_RST_KSEL 4'h0
`define IFMU_RST_KCMP 4'hF
`define IFMU_RST_GRP 6'h00
`define IFMU_GRP_PT 0
`define IFMU_GRP_SER 1
`define IFMU_GRP_K0 2
`define IFMU_GRP_K1 3
`define IFMU_GRP_CLK 4
`define IFMU_GRP_SW 5
`endif

// >>> common/ifmu_pkg.sv
package ifmu_pkg;
	// Peripheral events, one-cycle pulses on core_clk
	typedef struct packed {
		logic [1:0] progTimer;
		logic serial;
		logic [3:0] clockTimer;
		logic [1:0] stopwatch;
	} ifmu_evt_t;
	typedef enum logic [1:0] {SP_NONE, SP_WIDE_ONLY, SP_NIBBLE_ONLY, SP_READY} ifmu_sp_state_t;
endpackage

// >>> design/ifmu_top.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "ifmu_regs.svh"
module ifmu_top
	import ifmu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [17:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatIn,
	output logic [31:0] wbDatOut,
	output logic wbAck,
	input wire ifmu_evt_t periphEvt,
	input wire logic [3:0] keyPin0,
	input wire logic [3:0] keyPin1,
	input wire logic spWideWr,
	input wire logic spNibbleWr,
	input wire logic nmiSrc,
	output logic cpuIntReq,
	output logic cpuNmiReq,
	output logic irq
);
	function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] set,
		input logic [3:0] clr, input logic [3:0] bits);
		return ((cur & ~clr) | set) & bits;
	endfunction
	function automatic logic keyHit(input logic [3:0] k, input logic [3:0] cmp,
		input logic [3:0] sel);
		return |((k ^ cmp) & sel);
	endfunction

	logic [15:0] regIdx;
	logic reqNew;
	logic wrEn;
	logic rdEn;
	logic [3:0] wd;
	logic [31:0] next_rdData;
	logic [3:0] keySel0, keySel1, keyCmp0, keyCmp1;
	logic [3:0] mPt, mSer, mK0, mK1, mClk, mSw;
	logic [3:0] pPt, pSer, pK0, pK1, pClk, pSw;
	logic [5:0] grpStat, grpMask, statSnap, grpEvt;
	logic [3:0] k0s1, k0s2, k0s3, k1s1, k1s2, k1s3, key0, key1;
	logic hit0Q, hit1Q, k0Evt, k1Evt;
	ifmu_sp_state_t spState;
	logic spReady;

	assign regIdx = wbAdr[17:2];
	assign reqNew = wbCyc && wbStb && !wbAck;
	// Effects land on the edge the master sees ack, never earlier
	assign wrEn = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
	assign rdEn = wbCyc && wbStb && wbAck && !wbWe;
	assign wd = wbDatIn[3:0];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wbAck <= 1'b0;
		end else begin
			wbAck <= reqNew;
		end
	end

	// Unmapped indices answer with zero data
	always_comb begin
		next_rdData = 32'h0000_0000;
		if (regIdx == `IFMU_IDX_KSEL0) begin
			next_rdData[3:0] = keySel0;
		end else if (regIdx == `IFMU_IDX_KCMP0) begin
			next_rdData[3:0] = keyCmp0;
		end else if (regIdx == `IFMU_IDX_KSEL1) begin
			next_rdData[3:0] = keySel1;
		end else if (regIdx == `IFMU_IDX_KCMP1) begin
			next_rdData[3:0] = keyCmp1;
		end else if (regIdx == `IFMU_IDX_MPT) begin
			next_rdData[3:0] = mPt;
		end else if (regIdx == `IFMU_IDX_MSER) begin
			next_rdData[3:0] = mSer;
		end else if (regIdx == `IFMU_IDX_MK0) begin
			next_rdData[3:0] = mK0;
		end else if (regIdx == `IFMU_IDX_MK1) begin
			next_rdData[3:0] = mK1;
		end else if (regIdx == `IFMU_IDX_MCLK) begin
			next_rdData[3:0] = mClk;
		end else if (regIdx == `IFMU_IDX_MSW) begin
			next_rdData[3:0] = mSw;
		end else if (regIdx == `IFMU_IDX_PPT) begin
			next_rdData[3:0] = pPt;
		end else if (regIdx == `IFMU_IDX_PSER) begin
			next_rdData[3:0] = pSer;
		end else if (regIdx == `IFMU_IDX_PK0) begin
			next_rdData[3:0] = pK0;
		end else if (regIdx == `IFMU_IDX_PK1) begin
			next_rdData[3:0] = pK1;
		end else if (regIdx == `IFMU_IDX_PCLK) begin
			next_rdData[3:0] = pClk;
		end else if (regIdx == `IFMU_IDX_PSW) begin
			next_rdData[3:0] = pSw;
		end else if (regIdx == `IFMU_IDX_ISTAT) begin
			next_rdData[5:0] = grpStat;
		end else if (regIdx == `IFMU_IDX_IMASK) begin
			next_rdData[5:0] = grpMask;
		end else if (regIdx == `IFMU_IDX_SPSTAT) begin
			next_rdData[0] = spReady;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wbDatOut <= 32'h0000_0000;
		end else if (reqNew) begin
			wbDatOut <= next_rdData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			keySel0 <= `IFMU_RST_KSEL;
			keySel1 <= `IFMU_RST_KSEL;
			keyCmp0 <= `IFMU_RST_KCMP;
			keyCmp1 <= `IFMU_RST_KCMP;
		end else if (wrEn) begin
			if (regIdx == `IFMU_IDX_KSEL0) begin
				keySel0 <= wd;
			end else if (regIdx == `IFMU_IDX_KCMP0) begin
				keyCmp0 <= wd;
			end else if (regIdx == `IFMU_IDX_KSEL1) begin
				keySel1 <= wd;
			end else if (regIdx == `IFMU_IDX_KCMP1) begin
				keyCmp1 <= wd;
			end
		end
	end

	// Masks keep only their implemented bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mPt <= `IFMU_RST_MASK;
			mSer <= `IFMU_RST_MASK;
			mK0 <= `IFMU_RST_MASK;
			mK1 <= `IFMU_RST_MASK;
			mClk <= `IFMU_RST_MASK;
			mSw <= `IFMU_RST_MASK;
			grpMask <= `IFMU_RST_GRP;
		end else if (wrEn) begin
			if (regIdx == `IFMU_IDX_MPT) begin
				mPt <= wd & `IFMU_BITS_PT;
			end else if (regIdx == `IFMU_IDX_MSER) begin
				mSer <= wd & `IFMU_BITS_ONE;
			end else if (regIdx == `IFMU_IDX_MK0) begin
				mK0 <= wd & `IFMU_BITS_ONE;
			end else if (regIdx == `IFMU_IDX_MK1) begin
				mK1 <= wd & `IFMU_BITS_ONE;
			end else if (regIdx == `IFMU_IDX_MCLK) begin
				mClk <= wd & `IFMU_BITS_CLK;
			end else if (regIdx == `IFMU_IDX_MSW) begin
				mSw <= wd & `IFMU_BITS_SW;
			end else if (regIdx == `IFMU_IDX_IMASK) begin
				grpMask <= wbDatIn[5:0];
			end
		end
	end

	// Key pins: three stages, a bit moves once stages two and three agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			k0s1 <= 4'h0;
			k0s2 <= 4'h0;
			k0s3 <= 4'h0;
			k1s1 <= 4'h0;
			k1s2 <= 4'h0;
			k1s3 <= 4'h0;
			key0 <= 4'h0;
			key1 <= 4'h0;
		end else begin
			k0s1 <= keyPin0;
			k0s2 <= k0s1;
			k0s3 <= k0s2;
			k1s1 <= keyPin1;
			k1s2 <= k1s1;
			k1s3 <= k1s2;
			key0 <= (k0s2 & k0s3) | (key0 & (k0s2 | k0s3));
			key1 <= (k1s2 & k1s3) | (key1 & (k1s2 | k1s3));
		end
	end

	// A group fires when a selected key starts to differ from its comparison bit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hit0Q <= 1'b0;
			hit1Q <= 1'b0;
		end else begin
			hit0Q <= keyHit(key0, keyCmp0, keySel0);
			hit1Q <= keyHit(key1, keyCmp1, keySel1);
		end
	end
	assign k0Evt = keyHit(key0, keyCmp0, keySel0) && !hit0Q;
	assign k1Evt = keyHit(key1, keyCmp1, keySel1) && !hit1Q;

	// Pending flags: set regardless of mask, write 1 clears, set wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pPt <= `IFMU_RST_FLAG;
			pSer <= `IFMU_RST_FLAG;
			pK0 <= `IFMU_RST_FLAG;
			pK1 <= `IFMU_RST_FLAG;
			pClk <= `IFMU_RST_FLAG;
			pSw <= `IFMU_RST_FLAG;
		end else begin
			pPt <= w1c(pPt, {2'b00, periphEvt.progTimer},
				(wrEn && regIdx == `IFMU_IDX_PPT) ? wd : 4'h0, `IFMU_BITS_PT);
			pSer <= w1c(pSer, {3'b000, periphEvt.serial},
				(wrEn && regIdx == `IFMU_IDX_PSER) ? wd : 4'h0, `IFMU_BITS_ONE);
			pK0 <= w1c(pK0, {3'b000, k0Evt},
				(wrEn && regIdx == `IFMU_IDX_PK0) ? wd : 4'h0, `IFMU_BITS_ONE);
			pK1 <= w1c(pK1, {3'b000, k1Evt},
				(wrEn && regIdx == `IFMU_IDX_PK1) ? wd : 4'h0, `IFMU_BITS_ONE);
			pClk <= w1c(pClk, periphEvt.clockTimer,
				(wrEn && regIdx == `IFMU_IDX_PCLK) ? wd : 4'h0, `IFMU_BITS_CLK);
			pSw <= w1c(pSw, {2'b00, periphEvt.stopwatch},
				(wrEn && regIdx == `IFMU_IDX_PSW) ? wd : 4'h0, `IFMU_BITS_SW);
		end
	end

	// Stack pointer pairing gate
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			spState <= SP_NONE;
		end else begin
			case (spState)
				SP_NONE: begin
					if (spWideWr && spNibbleWr) spState <= SP_READY;
					else if (spWideWr) spState <= SP_WIDE_ONLY;
					else if (spNibbleWr) spState <= SP_NIBBLE_ONLY;
				end
				SP_WIDE_ONLY: begin
					if (spNibbleWr) spState <= SP_READY;
				end
				SP_NIBBLE_ONLY: begin
					if (spWideWr) spState <= SP_READY;
				end
				SP_READY: begin
					if (spWideWr && spNibbleWr) spState <= SP_READY;
					else if (spWideWr) spState <= SP_WIDE_ONLY;
					else if (spNibbleWr) spState <= SP_NIBBLE_ONLY;
				end
				default: spState <= SP_NONE;
			endcase
		end
	end
	assign spReady = (spState == SP_READY);

	// Level request re-fires by itself once the core re-enables or returns
	assign cpuIntReq = spReady && (|(pPt & mPt) || |(pSer & mSer) || |(pK0 & mK0)
		|| |(pK1 & mK1) || |(pClk & mClk) || |(pSw & mSw));
	assign cpuNmiReq = spReady && nmiSrc;

	// Group status: sticky, cleared by reading; only bits the read returned clear
	assign grpEvt[`IFMU_GRP_PT] = |periphEvt.progTimer;
	assign grpEvt[`IFMU_GRP_SER] = periphEvt.serial;
	assign grpEvt[`IFMU_GRP_K0] = k0Evt;
	assign grpEvt[`IFMU_GRP_K1] = k1Evt;
	assign grpEvt[`IFMU_GRP_CLK] = |periphEvt.clockTimer;
	assign grpEvt[`IFMU_GRP_SW] = |periphEvt.stopwatch;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			statSnap <= `IFMU_RST_GRP;
		end else if (reqNew) begin
			statSnap <= grpStat;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			grpStat <= `IFMU_RST_GRP;
		end else if (rdEn && regIdx == `IFMU_IDX_ISTAT) begin
			grpStat <= (grpStat & ~statSnap) | grpEvt;
		end else begin
			grpStat <= grpStat | grpEvt;
		end
	end
	assign irq = |(grpStat & grpMask);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence clkReadReq_s;
		reqNew && !wbWe && regIdx == `IFMU_IDX_PCLK;
	endsequence
	sequence ackSeen_s;
		##1 wbAck;
	endsequence
	sequence clrPt0_s;
		wrEn && regIdx == `IFMU_IDX_PPT && wd[0];
	endsequence

	busAck_a: assert property (reqNew |=> wbAck ##1 !wbAck)
		else $error("ack not a single pulse one cycle after request");
	flagMasked_a: assert property (
		periphEvt.progTimer[0] && !mPt[0] |=> pPt[0])
		else $error("masked timer event did not set its flag");
	reRaise_a: assert property (
		spReady && pSw[1] && mSw[1] && !(wrEn && regIdx == `IFMU_IDX_PSW)
		&& !spWideWr && !spNibbleWr |=> cpuIntReq)
		else $error("uncleared unmasked flag stopped requesting");
	spBlock_a: assert property (!spReady |-> !cpuIntReq && !cpuNmiReq)
		else $error("interrupt passed before both stack pointers set");
	spRelock_a: assert property (
		spReady && spWideWr && !spNibbleWr |=> (!cpuNmiReq && !spReady) [*1] ##0 !cpuIntReq)
		else $error("rewriting one stack pointer did not block");
	unusedZero_a: assert property (pPt[3:2] == 2'b00 && pSw[3:2] == 2'b00
		&& mSer[3:1] == 3'b000 && pK1[3:1] == 3'b000)
		else $error("unused flag or mask bit holds a one");
	clrFlag_a: assert property (
		clrPt0_s ##0 !periphEvt.progTimer[0] |=> !pPt[0])
		else $error("write of 1 did not clear timer flag");
	setWins_a: assert property (
		clrPt0_s ##0 periphEvt.progTimer[0] |=> pPt[0])
		else $error("event lost against a clearing write");
	clkRead_a: assert property (
		clkReadReq_s ##0 ackSeen_s |-> wbDatOut[3:0] == $past(pClk))
		else $error("clock timer flags read back wrong");
	keySel_a: assert property (keySel0 == 4'h0 |-> !k0Evt)
		else $error("unselected keys raised a group event");
endmodule // ifmu_top

// >>> testbench/ifmu_core_model.sv
`timescale 1ns/10ps
module ifmu_core_model
	import ifmu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ifmu_evt_t fireEvt,
	input wire logic fireWide,
	input wire logic fireNibble,
	output ifmu_evt_t periphEvt,
	output logic spWideWr,
	output logic spNibbleWr
);
	// Registered so every event and pointer write is a clean one-cycle pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			periphEvt <= '0;
			spWideWr <= 1'b0;
			spNibbleWr <= 1'b0;
		end else begin
			periphEvt <= fireEvt;
			spWideWr <= fireWide;
			spNibbleWr <= fireNibble;
		end
	end
endmodule // ifmu_core_model

// >>> testbench/ifmu_top_tb.sv
`timescale 1ns/10ps
`include "ifmu_regs.svh"
module ifmu_top_tb
	import ifmu_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, nmiSrc = 1'b0;
	logic [17:0] wbAdr = '0;
	logic [3:0] wbSel = '0, keyPin0 = 4'hF, keyPin1 = 4'hF;
	logic [31:0] wbDatIn = '0, wbDatOut, rd;
	ifmu_evt_t fireEvt = '0, periphEvt;
	logic fireWide = 1'b0, fireNibble = 1'b0, spWideWr, spNibbleWr, cpuIntReq, cpuNmiReq, irq;
	int failures = 0, checks = 0;
	logic [8:0] mapEvt [0:8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004,
		9'h002, 9'h001};
	logic [15:0] mapIdx [0:8] = '{`IFMU_IDX_PPT, `IFMU_IDX_PPT, `IFMU_IDX_PSER, `IFMU_IDX_PCLK,
		`IFMU_IDX_PCLK, `IFMU_IDX_PCLK, `IFMU_IDX_PCLK, `IFMU_IDX_PSW, `IFMU_IDX_PSW};
	logic [3:0] mapBit [0:8] = '{4'h2, 4'h1, 4'h1, 4'h8, 4'h4, 4'h2, 4'h1, 4'h2, 4'h1};
	logic [15:0] mskIdx [0:5] = '{`IFMU_IDX_MPT, `IFMU_IDX_MSER, `IFMU_IDX_MK0, `IFMU_IDX_MK1,
		`IFMU_IDX_MCLK, `IFMU_IDX_MSW};
	logic [3:0] mskBit [0:5] = '{4'h3, 4'h1, 4'h1, 4'h1, 4'hF, 4'h3};

	always #25 core_clk = ~core_clk;

	ifmu_core_model u_core (.core_clk(core_clk), .rst(rst), .fireEvt(fireEvt),
		.fireWide(fireWide), .fireNibble(fireNibble), .periphEvt(periphEvt),
		.spWideWr(spWideWr), .spNibbleWr(spNibbleWr));

	ifmu_top u_dut (.core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
		.periphEvt(periphEvt), .keyPin0(keyPin0), .keyPin1(keyPin1), .spWideWr(spWideWr),
		.spNibbleWr(spNibbleWr), .nmiSrc(nmiSrc), .cpuIntReq(cpuIntReq),
		.cpuNmiReq(cpuNmiReq), .irq(irq));

	task automatic summarize;
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Ack is read in the active region, so it is the value the edge samples
	task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbSel <= 4'h1;
		wbDatIn <= dat;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		rd = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
		wb(1'b0, idx, 32'h0);
		chk(what, rd, exp);
	endtask

	task automatic pulse(input logic [8:0] ev);
		@(posedge core_clk);
		fireEvt <= ifmu_evt_t'(ev);
		@(posedge core_clk);
		fireEvt <= '0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic sp(input logic w, input logic n);
		@(posedge core_clk);
		fireWide <= w;
		fireNibble <= n;
		@(posedge core_clk);
		fireWide <= 1'b0;
		fireNibble <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_reset;
		nmiSrc <= 1'b1;
		rdchk(`IFMU_IDX_PCLK, 32'h0, "clock flags");
		rdchk(`IFMU_IDX_KCMP0, 32'hF, "key compare");
		wb(1'b1, `IFMU_IDX_MPT, 32'h1);
		pulse(9'h080);
		chk("nmi", 32'(cpuNmiReq), 32'h0);
		chk("int", 32'(cpuIntReq), 32'h0);
	endtask

	task automatic t_stack;
		sp(1'b1, 1'b0);
		chk("nmi", 32'(cpuNmiReq), 32'h0);
		sp(1'b0, 1'b1);
		chk("nmi", 32'(cpuNmiReq), 32'h1);
		chk("int", 32'(cpuIntReq), 32'h1);
		sp(1'b1, 1'b0);
		chk("nmi", 32'(cpuNmiReq), 32'h0);
		chk("int", 32'(cpuIntReq), 32'h0);
		sp(1'b0, 1'b1);
		chk("nmi", 32'(cpuNmiReq), 32'h1);
		wb(1'b1, `IFMU_IDX_MPT, 32'h0);
		wb(1'b1, `IFMU_IDX_PPT, 32'h1);
	endtask

	// Event lands on the very edge that the clearing write takes effect
	task automatic t_race;
		fork
			wb(1'b1, `IFMU_IDX_PPT, 32'h1);
			begin
				@(posedge core_clk);
				fireEvt <= ifmu_evt_t'(9'h080);
				@(posedge core_clk);
				fireEvt <= '0;
			end
		join
		rdchk(`IFMU_IDX_PPT, 32'h1, "set beats clear");
		wb(1'b1, `IFMU_IDX_PPT, 32'h1);
		rdchk(`IFMU_IDX_PPT, 32'h0, "flag cleared");
	endtask

	task automatic t_map;
		for (int i = 0; i < 9; i++) begin
			pulse(mapEvt[i]);
			chk("int", 32'(cpuIntReq), 32'h0);
			rdchk(mapIdx[i], {28'h0, mapBit[i]}, "flag");
			wb(1'b1, mapIdx[i], 32'h0);
			rdchk(mapIdx[i], {28'h0, mapBit[i]}, "flag kept");
			wb(1'b1, mapIdx[i], 32'hF);
			rdchk(mapIdx[i], 32'h0, "flag cleared");
		end
	endtask

	task automatic t_mask;
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, mskIdx[i], 32'hF);
			rdchk(mskIdx[i], {28'h0, mskBit[i]}, "mask");
		end
		wb(1'b1, 16'hFF40, 32'hF);
		rdchk(16'hFF40, 32'h0, "unmapped");
		pulse(9'h100);
		chk("int", 32'(cpuIntReq), 32'h1);
		wb(1'b1, `IFMU_IDX_PPT, 32'h0);
		chk("int", 32'(cpuIntReq), 32'h1);
		wb(1'b1, `IFMU_IDX_PPT, 32'h2);
		@(posedge core_clk);
		chk("int", 32'(cpuIntReq), 32'h0);
		pulse(9'h002);
		chk("int", 32'(cpuIntReq), 32'h1);
		wb(1'b1, `IFMU_IDX_PSW, 32'h2);
		rdchk(`IFMU_IDX_PSW, 32'h0, "flag cleared");
	endtask

	// Pins pass a three-flop synchroniser, so allow eight edges to settle
	task automatic t_keys;
		wb(1'b1, `IFMU_IDX_KSEL0, 32'h1);
		keyPin0 <= 4'hD;
		repeat (8) @(posedge core_clk);
		rdchk(`IFMU_IDX_PK0, 32'h0, "unselected key");
		keyPin0 <= 4'hC;
		repeat (8) @(posedge core_clk);
		rdchk(`IFMU_IDX_PK0, 32'h1, "selected key");
		wb(1'b1, `IFMU_IDX_KCMP1, 32'h0);
		wb(1'b1, `IFMU_IDX_KSEL1, 32'h8);
		rdchk(`IFMU_IDX_KSEL1, 32'h8, "key select");
		repeat (8) @(posedge core_clk);
		rdchk(`IFMU_IDX_PK1, 32'h1, "group one key");
	endtask

	task automatic t_irq;
		wb(1'b1, `IFMU_IDX_IMASK, 32'h01);
		wb(1'b0, `IFMU_IDX_ISTAT, 32'h0);
		@(posedge core_clk);
		chk("irq idle", 32'(irq), 32'h0);
		pulse(9'h080);
		chk("irq raised", 32'(irq), 32'h1);
		rdchk(`IFMU_IDX_ISTAT, 32'h01, "group status");
		@(posedge core_clk);
		chk("irq cleared", 32'(irq), 32'h0);
		wb(1'b1, `IFMU_IDX_IMASK, 32'h0);
		pulse(9'h040);
		chk("irq masked", 32'(irq), 32'h0);
		rdchk(`IFMU_IDX_ISTAT, 32'h02, "group status");
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_stack();
		t_race();
		t_map();
		t_mask();
		t_keys();
		t_irq();
		summarize();
	end

	// The whole sequence needs well under two thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		summarize();
	end
endmodule // ifmu_top_tb
